// File: rml_pkg.sv
// Constants, types and register map of the radio mode and link control
package rml_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_PS       = 4000;
  localparam int SETTLE_TIME_US      = 130;
  localparam int GAIN_SETTLE_TIME_US = 40;
  localparam int RETRY_UNIT_TIME_US  = 250;
  // Longest time rounds down, least time rounds up
  localparam int SETTLE_CYC = (SETTLE_TIME_US * 1000000) / CLK_PERIOD_PS;
  localparam int GAIN_SETTLE_CYC =
    (GAIN_SETTLE_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RETRY_UNIT_CYC =
    (RETRY_UNIT_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TMR_W = 20;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [4:0] REG_CONFIG      = 5'h00;
  localparam logic [4:0] REG_RETRY_SETUP = 5'h04;
  localparam logic [4:0] REG_CHANNEL     = 5'h05;
  localparam logic [4:0] REG_RADIO_SETUP = 5'h06;
  localparam logic [4:0] REG_RX_POWER    = 5'h09;
  localparam int CFG_PRIMARY_RECEIVER_SELECT_BIT  = 0;
  localparam int CFG_POWER_ON_BIT = 1;
  localparam int RS_PWR_LSB       = 1;
  localparam int RS_RATE_HI_BIT   = 3;
  localparam int RS_RATE_LO_BIT   = 5;
  localparam int RT_LIMIT_LSB     = 0;
  localparam int RT_DELAY_LSB     = 4;
  localparam int CMD_WRITE_BIT    = 5;
  localparam logic [7:0] CONFIG_RST      = 8'h00;
  localparam logic [7:0] RETRY_SETUP_RST = 8'h03;
  localparam logic [7:0] CHANNEL_RST     = 8'h02;
  localparam logic [7:0] RADIO_SETUP_RST = 8'h0e;
  localparam logic [11:0] BASE_FREQ_MHZ  = 12'h960;
  localparam logic [5:0]  MAX_PAYLOAD    = 6'h20;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [6:0] {
    ST_OFF    = 7'h01,
    ST_STBY   = 7'h02,
    ST_SET_TX = 7'h04,
    ST_SET_RX = 7'h08,
    ST_TX     = 7'h10,
    ST_RX     = 7'h20,
    ST_WAIT   = 7'h40
  } rml_state_t;

  typedef enum logic [1:0] {
    RATE_1M   = 2'h0,
    RATE_2M   = 2'h1,
    RATE_250K = 2'h2
  } rml_rate_t;

  typedef struct packed {
    logic       last;
    logic [7:0] data;
  } rml_byte_t;

endpackage : rml_pkg

// File: rml_radio_ctrl.sv
// Mode sequencer, SPI registers and link handling of the radio
`timescale 1ns/1ps
`default_nettype none
module rml_radio_ctrl
#(
  parameter int SETTLE_CYCLES      = rml_pkg::SETTLE_CYC,
  parameter int GAIN_SETTLE_CYCLES = rml_pkg::GAIN_SETTLE_CYC,
  parameter int RETRY_UNIT_CYCLES  = rml_pkg::RETRY_UNIT_CYC
)
(
  input  wire logic              ref_clk,        // Reference clock
  input  wire logic              rst,            // Async reset
  input  wire logic              ce_pin,         // Chip enable pin
  input  wire logic              csn_n_pin,      // Serial select
  input  wire logic              sck_pin,        // Serial clock
  input  wire logic              mosi_pin,       // Serial data in
  output logic                   miso_o,         // Serial data out
  output logic                   miso_oe_n,      // Low while driving
  input  wire logic              power_det_in,   // Analog power compare
  input  wire logic              pkt_valid,      // Address and CRC good
  input  wire logic              pkt_no_ack,     // Packet wants no ack
  input  wire logic              ack_rcvd,       // Ack packet seen
  input  wire logic              tx_done,        // Packet sent on air
  input  wire logic              rx_timeout,     // Ack wait expired
  input  wire logic              tx_pending,     // TX payload present
  input  wire logic              rx_full,        // All RX slots taken
  input  wire rml_pkg::rml_byte_t pl_in,         // Received byte
  input  wire logic              pl_in_valid,    // Byte valid
  output logic                   pl_in_ready,    // Buffer has room
  output rml_pkg::rml_byte_t     pl_out,         // Byte to RX slot
  output logic                   pl_out_valid,   // Buffer not empty
  input  wire logic              pl_out_ready,   // RX slot takes byte
  output rml_pkg::rml_state_t    mode,           // Current mode
  output logic                   synth_on,       // Synthesizer running
  output logic                   tx_on,          // Transmitter on
  output logic                   rx_on,          // Receiver hunting
  output logic                   ack_tx,         // Sending an ack
  output logic                   resend,         // Retransmit pulse
  output logic                   tx_complete,    // Ack received pulse
  output logic                   retry_fail,     // Limit reached pulse
  output rml_pkg::rml_rate_t     air_rate,       // Air data rate
  output logic [11:0]            carrier_mhz,    // Carrier frequency
  output logic [4:0]             pa_atten_db     // Output power below 0dBm
);
  import rml_pkg::*;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic rml_rate_t rate_dec(input logic [7:0] rs);
    unique case ({rs[RS_RATE_LO_BIT], rs[RS_RATE_HI_BIT]})
      2'b00:   rate_dec = RATE_1M;
      2'b01:   rate_dec = RATE_2M;
      default: rate_dec = RATE_250K;
    endcase
  endfunction

  function automatic logic [4:0] pa_dec(input logic [1:0] lvl);
    unique case (lvl)
      2'b11: pa_dec = 5'h00;
      2'b10: pa_dec = 5'h06;
      2'b01: pa_dec = 5'h0c;
      2'b00: pa_dec = 5'h12;
    endcase
  endfunction

  // ****************************************************************
  // Synchronisers
  // ****************************************************************
  logic [4:0] sync1_r;
  logic [4:0] sync2_r;
  logic       sck_d_r;
  logic       ce, csn_n, sck, mosi, pdet;

  // Two flops on every pin input
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      sync1_r <= 5'h02;
      sync2_r <= 5'h02;
      sck_d_r <= 1'b0;
    end
    else
    begin
      sync1_r <= {power_det_in, mosi_pin, sck_pin, csn_n_pin, ce_pin};
      sync2_r <= sync1_r;
      sck_d_r <= sync2_r[2];
    end

  assign ce    = sync2_r[0];
  assign csn_n = sync2_r[1];
  assign sck   = sync2_r[2];
  assign mosi  = sync2_r[3];
  assign pdet  = sync2_r[4];

  // ****************************************************************
  // SPI slave
  // ****************************************************************
  logic       sck_rise, sck_fall;
  logic [2:0] bit_r;
  logic [7:0] sin_r;
  logic [7:0] sout_r;
  logic [7:0] cmd_r;
  logic       have_cmd_r;
  logic [7:0] cfg_r, retry_r, chan_r, rsetup_r;
  logic [7:0] rdata;
  logic       rpd_live, rpd_r;
  logic [7:0] byte_in;
  logic       byte_done;

  assign sck_rise  = sck & ~sck_d_r & ~csn_n;
  assign sck_fall  = ~sck & sck_d_r & ~csn_n;
  assign byte_in   = {sin_r[6:0], mosi};
  assign byte_done = sck_rise && (bit_r == 3'h7);

  // Read mux, unmapped addresses read zero
  always_comb
  begin
    rdata = 8'h00;
    unique case (cmd_r[4:0])
      REG_CONFIG:      rdata = cfg_r;
      REG_RETRY_SETUP: rdata = retry_r;
      REG_CHANNEL:     rdata = chan_r;
      REG_RADIO_SETUP: rdata = rsetup_r;
      REG_RX_POWER:    rdata = {7'h00, rpd_live};
      default:         rdata = 8'h00;
    endcase
  end

  // Shift in on rise, shift out on fall
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      bit_r      <= 3'h0;
      sin_r      <= 8'h00;
      sout_r     <= 8'h00;
      cmd_r      <= 8'h00;
      have_cmd_r <= 1'b0;
    end
    else if (csn_n)
    begin
      bit_r      <= 3'h0;
      sout_r     <= 8'h00;
      have_cmd_r <= 1'b0;
    end
    else
    begin
      if (sck_rise)
      begin
        bit_r <= bit_r + 3'h1;
        sin_r <= byte_in;
      end
      if (byte_done && !have_cmd_r)
      begin
        cmd_r      <= byte_in;
        have_cmd_r <= 1'b1;
      end
      if (sck_fall && bit_r == 3'h0 && have_cmd_r)
        sout_r <= rdata;
      else if (sck_fall)
        sout_r <= {sout_r[6:0], 1'b0};
    end

  assign miso_o    = sout_r[7];
  assign miso_oe_n = csn_n;

  // Register writes on each data byte of a write command
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      cfg_r    <= CONFIG_RST;
      retry_r  <= RETRY_SETUP_RST;
      chan_r   <= CHANNEL_RST;
      rsetup_r <= RADIO_SETUP_RST;
    end
    else if (byte_done && have_cmd_r && cmd_r[CMD_WRITE_BIT])
      unique case (cmd_r[4:0])
        REG_CONFIG:      cfg_r    <= byte_in;
        REG_RETRY_SETUP: retry_r  <= byte_in;
        REG_CHANNEL:     chan_r   <= {1'b0, byte_in[6:0]};
        REG_RADIO_SETUP: rsetup_r <= byte_in;
        default:         cfg_r    <= cfg_r;
      endcase

  // ****************************************************************
  // Radio settings
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      air_rate    <= RATE_1M;
      carrier_mhz <= BASE_FREQ_MHZ;
      pa_atten_db <= 5'h00;
    end
    else
    begin
      air_rate    <= rate_dec(rsetup_r);
      carrier_mhz <= BASE_FREQ_MHZ + {5'h00, chan_r[6:0]};
      pa_atten_db <= pa_dec(rsetup_r[RS_PWR_LSB +: 2]);
    end

  // ****************************************************************
  // Mode sequencer
  // ****************************************************************
  rml_state_t       st_r, st_nxt;
  logic [TMR_W-1:0] tmr_r;
  logic             tmr_zero;
  logic             ack_wait_r;
  logic [3:0]       retry_cnt_r;
  logic             pwr, primary_receiver_role;
  logic             enter;

  assign pwr      = cfg_r[CFG_POWER_ON_BIT];
  assign primary_receiver_role      = cfg_r[CFG_PRIMARY_RECEIVER_SELECT_BIT];
  assign tmr_zero = (tmr_r == '0);
  assign enter    = (st_nxt != st_r);

  // Next mode
  always_comb
  begin
    st_nxt = st_r;
    unique case (st_r)
      ST_OFF:
        if (pwr)
          st_nxt = ST_STBY;
      ST_STBY:
        if (ce && primary_receiver_role)
          st_nxt = ST_SET_RX;
        else if (ce && tx_pending)
          st_nxt = ST_SET_TX;
      ST_SET_TX:
        if (tmr_zero)
          st_nxt = ST_TX;
      ST_SET_RX:
        if (!ce && !ack_wait_r)
          st_nxt = ST_STBY;
        else if (tmr_zero)
          st_nxt = ST_RX;
      ST_TX:
        if (tx_done && !primary_receiver_role && !pkt_no_ack)
          st_nxt = ST_SET_RX;
        else if (tx_done)
          st_nxt = ce ? ST_SET_RX : ST_STBY;
      ST_RX:
        if (ack_wait_r && ack_rcvd)
          st_nxt = ST_STBY;
        else if (ack_wait_r && rx_timeout)
          st_nxt = (retry_cnt_r < retry_r[RT_LIMIT_LSB +: 4]) ?
                   ST_WAIT : ST_STBY;
        else if (!ack_wait_r && (!ce || !primary_receiver_role))
          st_nxt = ST_STBY;
        else if (!ack_wait_r && pkt_valid && !pkt_no_ack)
          st_nxt = ST_SET_TX;
      ST_WAIT:
        if (tmr_zero)
          st_nxt = ST_SET_TX;
    endcase
    if (!pwr)
      st_nxt = ST_OFF;
  end

  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      st_r <= ST_OFF;
    else
      st_r <= st_nxt;

  // Settling and retry delay timer
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      tmr_r <= '0;
    else if (enter && (st_nxt == ST_SET_TX || st_nxt == ST_SET_RX))
      tmr_r <= TMR_W'(SETTLE_CYCLES - 1);
    else if (enter && st_nxt == ST_WAIT)
      tmr_r <= TMR_W'((retry_r[RT_DELAY_LSB +: 4] + 1) *
                      RETRY_UNIT_CYCLES - 1);
    else if (!tmr_zero)
      tmr_r <= tmr_r - 1'b1;

  // Transaction role and retry count
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      ack_wait_r  <= 1'b0;
      retry_cnt_r <= 4'h0;
    end
    else if (st_r == ST_TX && tx_done)
    begin
      ack_wait_r <= !primary_receiver_role && !pkt_no_ack;
    end
    else if (st_r == ST_STBY || st_r == ST_OFF)
    begin
      ack_wait_r  <= 1'b0;
      retry_cnt_r <= 4'h0;
    end
    else if (st_nxt == ST_WAIT && enter)
      retry_cnt_r <= retry_cnt_r + 4'h1;

  // Event pulses
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      tx_complete <= 1'b0;
      retry_fail  <= 1'b0;
      resend      <= 1'b0;
    end
    else
    begin
      tx_complete <= st_r == ST_RX && ack_wait_r && ack_rcvd;
      retry_fail  <= st_r == ST_RX && ack_wait_r && rx_timeout &&
                     st_nxt == ST_STBY;
      resend      <= st_r == ST_WAIT && tmr_zero;
    end

  assign mode     = st_r;
  assign synth_on = st_r[2] | st_r[3] | st_r[4] | st_r[5];
  assign tx_on    = (st_r == ST_TX);
  assign rx_on    = (st_r == ST_RX);
  assign ack_tx   = tx_on & primary_receiver_role;

  // ****************************************************************
  // Received power flag
  // ****************************************************************
  logic [TMR_W-1:0] rx_age_r;
  logic             rx_settled;

  assign rx_settled = (rx_age_r == TMR_W'(GAIN_SETTLE_CYCLES));
  assign rpd_live   = (rx_on && rx_settled) ? pdet : rpd_r;

  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      rx_age_r <= '0;
    else if (!rx_on)
      rx_age_r <= '0;
    else if (!rx_settled)
      rx_age_r <= rx_age_r + 1'b1;

  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      rpd_r <= 1'b0;
    // latch on valid packet, or on rx end
    else if (rx_on && (pkt_valid || rx_timeout || st_nxt != ST_RX))
      rpd_r <= rx_settled & pdet;
    else
      rpd_r <= rpd_r;

  // ****************************************************************
  // Payload path and two-entry buffer
  // ****************************************************************
  rml_byte_t  buf_r [2];
  logic       wptr_r, rptr_r;
  logic [1:0] cnt_r;
  logic       keep_r, in_pkt_r;
  logic [5:0] len_r;
  logic       push, pop, take, first;

  assign pl_in_ready  = (cnt_r != 2'h2);
  assign pl_out_valid = (cnt_r != 2'h0);
  assign pl_out       = buf_r[rptr_r];
  assign take         = pl_in_valid && pl_in_ready;
  assign first        = take && !in_pkt_r;
  // drop when full, cap at 32
  assign push = take && (first ? !rx_full : keep_r) && len_r < MAX_PAYLOAD;
  assign pop  = pl_out_valid && pl_out_ready;

  // Packet keep decision and length
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      keep_r   <= 1'b0;
      in_pkt_r <= 1'b0;
      len_r    <= 6'h00;
    end
    else if (take)
    begin
      keep_r   <= first ? !rx_full : keep_r;
      in_pkt_r <= !pl_in.last;
      len_r    <= pl_in.last ? 6'h00 : len_r + 6'h01;
    end

  // Buffer storage and pointers
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      buf_r[0] <= '0;
      buf_r[1] <= '0;
      wptr_r   <= 1'b0;
      rptr_r   <= 1'b0;
      cnt_r    <= 2'h0;
    end
    else
    begin
      if (push)
      begin
        buf_r[wptr_r] <= pl_in;
        wptr_r        <= ~wptr_r;
      end
      if (pop)
        rptr_r <= ~rptr_r;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end

endmodule : rml_radio_ctrl
`default_nettype wire

// File: rml_chk.sv
// Assertion checker for the radio mode and link control
`timescale 1ns/1ps
`default_nettype none
module rml_chk
  import rml_pkg::*;
#(
  parameter int SETTLE_CYCLES = 20
)
(
  input wire logic               ref_clk,      // Clock
  input wire logic               rst,          // Reset
  input wire logic               tx_done,      // Sent pulse
  input wire logic               pkt_valid,    // Packet pulse
  input wire logic               pkt_no_ack,   // No ack wanted
  input wire logic               ack_rcvd,     // Ack pulse
  input wire rml_pkg::rml_byte_t pl_out,       // Buffer head
  input wire logic               pl_out_valid, // Head valid
  input wire logic               pl_out_ready, // Head taken
  input wire rml_pkg::rml_state_t mode,        // Mode
  input wire logic               ack_tx,       // Ack sending
  input wire logic               resend,       // Retry pulse
  input wire logic               tx_complete,  // Done pulse
  input wire logic [4:0]         pa_atten_db   // Power step
);
  // ****************************************************
  // Settle timer and properties
  // ****************************************************
  logic [19:0] set_cnt_r; // Cycles spent settling

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // Count settle cycles
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      set_cnt_r <= '0;
    else if (mode inside {ST_SET_TX, ST_SET_RX})
      set_cnt_r <= set_cnt_r + 20'h1;
    else
      set_cnt_r <= '0;

  sequence s_settled;
    $past(mode) inside {ST_SET_TX, ST_SET_RX} ##0 mode inside {ST_TX, ST_RX};
  endsequence
  sequence s_ack_in;
    mode == ST_RX && ack_rcvd;
  endsequence

  property p_settle;
    s_settled |-> $past(set_cnt_r) inside {[SETTLE_CYCLES-1:SETTLE_CYCLES]};
  endproperty
  property p_off;
    mode == ST_OFF |=> mode inside {ST_OFF, ST_STBY};
  endproperty
  property p_pa;
    pa_atten_db inside {5'h00, 5'h06, 5'h0c, 5'h12};
  endproperty
  property p_hold;
    pl_out_valid && !pl_out_ready |=> pl_out_valid && $stable(pl_out);
  endproperty
  property p_turn;
    mode == ST_TX && tx_done && !pkt_no_ack && !ack_tx |=> mode == ST_SET_RX;
  endproperty
  property p_ack;
    mode == ST_RX && pkt_valid && !pkt_no_ack |=> mode == ST_SET_TX;
  endproperty
  property p_resend;
    resend |-> $past(mode) == ST_WAIT;
  endproperty
  property p_done;
    s_ack_in |-> ##[1:2] tx_complete ##1 !tx_complete;
  endproperty

  a_settle: assert property (p_settle) else $error("settle length wrong");
  a_off: assert property (p_off) else $error("left off not via standby");
  a_pa: assert property (p_pa) else $error("power step illegal");
  a_hold: assert property (p_hold) else $error("buffer head changed");
  a_turn: assert property (p_turn) else $error("no turn to receive");
  a_ack: assert property (p_ack) else $error("no ack sent");
  a_resend: assert property (p_resend) else $error("resend not after wait");
  a_done: assert property (p_done) else $error("completion pulse wrong");
endmodule // rml_chk

bind rml_radio_ctrl rml_chk #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_rml_chk (
  .ref_clk(ref_clk), .rst(rst), .tx_done(tx_done), .pkt_valid(pkt_valid),
  .pkt_no_ack(pkt_no_ack), .ack_rcvd(ack_rcvd), .pl_out(pl_out),
  .pl_out_valid(pl_out_valid), .pl_out_ready(pl_out_ready), .mode(mode),
  .ack_tx(ack_tx), .resend(resend), .tx_complete(tx_complete),
  .pa_atten_db(pa_atten_db));
`default_nettype wire

// File: rml_host_model.sv
// Host controller model driving the serial port
`timescale 1ns/1ps
`default_nettype none
module rml_host_model
(
  input  wire logic ce_pin,    // Chip enable seen
  input  wire logic miso_o,    // Serial data back
  output logic      csn_n_pin, // Serial select
  output logic      sck_pin,   // Serial clock
  output logic      mosi_pin   // Serial data out
);
  // ****************************************************
  // Serial frames
  // ****************************************************
  realtime ce_rise_t; // Last chip enable rise

  initial
  begin
    csn_n_pin = 1'b1;
    sck_pin = 1'b0;
    mosi_pin = 1'b0;
    ce_rise_t = -1.0e9;
  end

  // Remember chip enable rises
  always @(posedge ce_pin)
    ce_rise_t = $realtime;

  // One command byte and one data byte, MSB first
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd,
                      output logic [7:0] rd);
    logic [15:0] sh;
    sh = {cmd, wd};
    rd = 8'h00;
    // select waits 4us after enable rise
    while ($realtime - ce_rise_t < 4000.0)
      #10;
    #37 csn_n_pin = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      mosi_pin = sh[i];
      #80 sck_pin = 1'b1;
      if (i < 8)
        rd = {rd[6:0], miso_o};
      #80 sck_pin = 1'b0;
    end
    #80 csn_n_pin = 1'b1;
    mosi_pin = ~mosi_pin;
  endtask
endmodule // rml_host_model
`default_nettype wire

// File: rml_radio_ctrl_tb.sv
// Self-checking bench for the radio mode and link control
`timescale 1ns/1ps
`default_nettype none
module rml_radio_ctrl_tb;
  import rml_pkg::*;
  // ****************************************************
  // Signals and helpers
  // ****************************************************
  logic ref_clk = 0, rst = 1, ce_pin = 0, power_det_in = 0;
  logic pkt_valid = 0, pkt_no_ack = 0, ack_rcvd = 0, tx_done = 0;
  logic rx_timeout = 0, tx_pending = 0, rx_full = 0;
  logic pl_in_valid = 0, pl_out_ready = 0;
  rml_byte_t pl_in = '0;
  rml_byte_t pl_out;
  rml_state_t mode;
  rml_rate_t air_rate;
  logic csn_n_pin, sck_pin, mosi_pin, miso_o, miso_oe_n, pl_in_ready;
  logic pl_out_valid, synth_on, tx_on, rx_on, ack_tx, resend;
  logic tx_complete, retry_fail;
  logic [11:0] carrier_mhz;
  logic [4:0] pa_atten_db;
  int mismatches = 0, total_checks = 0, cyc = 0;
  int n_done = 0, n_rs = 0, n_fail = 0;

  rml_radio_ctrl #(.SETTLE_CYCLES(20), .GAIN_SETTLE_CYCLES(8),
    .RETRY_UNIT_CYCLES(10)) u_rml_radio_ctrl (
    .ref_clk(ref_clk), .rst(rst), .ce_pin(ce_pin), .csn_n_pin(csn_n_pin),
    .sck_pin(sck_pin), .mosi_pin(mosi_pin), .miso_o(miso_o),
    .miso_oe_n(miso_oe_n), .power_det_in(power_det_in),
    .pkt_valid(pkt_valid), .pkt_no_ack(pkt_no_ack), .ack_rcvd(ack_rcvd),
    .tx_done(tx_done), .rx_timeout(rx_timeout), .tx_pending(tx_pending),
    .rx_full(rx_full), .pl_in(pl_in), .pl_in_valid(pl_in_valid),
    .pl_in_ready(pl_in_ready), .pl_out(pl_out),
    .pl_out_valid(pl_out_valid), .pl_out_ready(pl_out_ready), .mode(mode),
    .synth_on(synth_on), .tx_on(tx_on), .rx_on(rx_on), .ack_tx(ack_tx),
    .resend(resend), .tx_complete(tx_complete), .retry_fail(retry_fail),
    .air_rate(air_rate), .carrier_mhz(carrier_mhz),
    .pa_atten_db(pa_atten_db));

  rml_host_model u_rml_host_model (.ce_pin(ce_pin), .miso_o(miso_o),
    .csn_n_pin(csn_n_pin), .sck_pin(sck_pin), .mosi_pin(mosi_pin));

  always #2 ref_clk = ~ref_clk;

  // Pulse tallies and hang guard
  always @(posedge ref_clk)
  begin
    cyc++;
    if (tx_complete === 1'b1) n_done++;
    if (resend === 1'b1) n_rs++;
    if (retry_fail === 1'b1) n_fail++;
    if (cyc == 80000)
    begin
      mismatches++;
      results();
    end
  end

  task automatic results();
    if (mismatches == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [11:0] e, g);
    total_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] r;
    u_rml_host_model.xfer({3'h1, a}, d, r);
    tick(4);
  endtask

  task automatic rd_chk(input string nm, input logic [4:0] a, logic [7:0] e);
    logic [7:0] r;
    u_rml_host_model.xfer({3'h0, a}, 8'h00, r);
    cmp(nm, {4'h0, e}, {4'h0, r});
  endtask

  task automatic wait_mode(input rml_state_t m);
    int k;
    k = 0;
    while (mode !== m && k < 300)
    begin
      @(negedge ref_clk);
      k++;
    end
    cmp("mode", {5'h0, m}, {5'h0, mode});
  endtask

  task automatic push(input logic [8:0] b);
    @(posedge ref_clk) pl_in <= b;
    pl_in_valid <= 1'b1;
    do @(negedge ref_clk); while (pl_in_ready !== 1'b1);
    @(posedge ref_clk) pl_in_valid <= 1'b0;
  endtask

  // ****************************************************
  // Scenarios
  // ****************************************************
  task automatic t_reset();
    cmp("mode", {5'h0, ST_OFF}, {5'h0, mode});
    cmp("miso_oe_n", 12'h1, {11'h0, miso_oe_n});
    cmp("carrier", 12'h962, carrier_mhz);
    rd_chk("rx_power", REG_RX_POWER, 8'h00);
    rd_chk("unmapped", 5'h1f, 8'h00);
  endtask

  task automatic t_radio();
    logic [7:0] v [4] = '{8'h00, 8'h0a, 8'h24, 8'h06};
    logic [4:0] at [4] = '{5'h12, 5'h0c, 5'h06, 5'h00};
    rml_rate_t rt [4] = '{RATE_1M, RATE_2M, RATE_250K, RATE_1M};
    wr(REG_CHANNEL, 8'h10);
    cmp("carrier", 12'h970, carrier_mhz);
    for (int i = 0; i < 4; i++)
    begin
      wr(REG_RADIO_SETUP, v[i]);
      cmp("pa_atten", {7'h0, at[i]}, {7'h0, pa_atten_db});
      cmp("air_rate", {10'h0, rt[i]}, {10'h0, air_rate});
    end
  endtask

  task automatic t_ptx();
    wr(REG_CONFIG, 8'h02);
    wait_mode(ST_STBY);
    tick(37500);
    tx_pending <= 1'b1;
    ce_pin <= 1'b1;
    wait_mode(ST_TX);
    cmp("tx_on", 12'h1, {11'h0, tx_on});
    cmp("synth_on", 12'h1, {11'h0, synth_on});
    tx_pending <= 1'b0;
    @(posedge ref_clk) tx_done <= 1'b1;
    @(posedge ref_clk) tx_done <= 1'b0;
    wait_mode(ST_RX);
    @(posedge ref_clk) ack_rcvd <= 1'b1;
    @(posedge ref_clk) ack_rcvd <= 1'b0;
    tick(4);
    cmp("tx_complete", 12'h1, n_done[11:0]);
    wait_mode(ST_STBY);
    tick(2500);
    ce_pin <= 1'b0;
  endtask

  task automatic t_retry();
    wr(REG_RETRY_SETUP, 8'h01);
    tx_pending <= 1'b1;
    ce_pin <= 1'b1;
    wait_mode(ST_TX);
    tx_pending <= 1'b0;
    for (int i = 0; i < 2; i++)
    begin
      @(posedge ref_clk) tx_done <= 1'b1;
      @(posedge ref_clk) tx_done <= 1'b0;
      wait_mode(ST_RX);
      @(posedge ref_clk) rx_timeout <= 1'b1;
      @(posedge ref_clk) rx_timeout <= 1'b0;
      if (i == 0)
        wait_mode(ST_TX);
    end
    wait_mode(ST_STBY);
    tick(2);
    cmp("resend", 12'h1, n_rs[11:0]);
    cmp("retry_fail", 12'h1, n_fail[11:0]);
    ce_pin <= 1'b0;
  endtask

  task automatic t_prx();
    wr(REG_CONFIG, 8'h03);
    power_det_in <= 1'b1;
    ce_pin <= 1'b1;
    wait_mode(ST_RX);
    cmp("rx_on", 12'h1, {11'h0, rx_on});
    push(9'h0a5);
    push(9'h15a);
    @(negedge ref_clk);
    cmp("in_ready", 12'h0, {11'h0, pl_in_ready});
    for (int i = 0; i < 2; i++)
    begin
      @(negedge ref_clk);
      cmp("pl_out", i ? 12'h15a : 12'h0a5, {3'h0, pl_out});
      @(posedge ref_clk) pl_out_ready <= 1'b1;
      @(posedge ref_clk) pl_out_ready <= 1'b0;
    end
    rx_full <= 1'b1;
    push(9'h1c3);
    tick(2);
    cmp("out_valid", 12'h0, {11'h0, pl_out_valid});
    rx_full <= 1'b0;
    rd_chk("rx_power", REG_RX_POWER, 8'h01);
    @(posedge ref_clk) pkt_valid <= 1'b1;
    @(posedge ref_clk) pkt_valid <= 1'b0;
    wait_mode(ST_TX);
    cmp("ack_tx", 12'h1, {11'h0, ack_tx});
    @(posedge ref_clk) tx_done <= 1'b1;
    @(posedge ref_clk) tx_done <= 1'b0;
    wait_mode(ST_RX);
    tick(10);
    pkt_no_ack <= 1'b1;
    @(posedge ref_clk) pkt_valid <= 1'b1;
    @(posedge ref_clk) pkt_valid <= 1'b0;
    tick(2);
    cmp("mode", {5'h0, ST_RX}, {5'h0, mode});
    pkt_no_ack <= 1'b0;
    ce_pin <= 1'b0;
    wait_mode(ST_STBY);
    power_det_in <= 1'b0;
    tick(4);
    rd_chk("rx_power", REG_RX_POWER, 8'h01);
  endtask

  // Main sequence
  initial
  begin
    tick(4);
    rst <= 1'b0;
    tick(2);
    t_reset();
    t_radio();
    t_ptx();
    t_retry();
    t_prx();
    results();
  end
endmodule // rml_radio_ctrl_tb
`default_nettype wire
